// *** camera_video_output_port.sv ***
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/10ps

module camera_video_output_port
	import video_out_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// sensor side
	input wire logic sensor_clk,
	input wire logic ext_trigger,
	input wire pixel_quad_t pixel_in,
	output logic pixel_take,
	input wire logic init_done,
	input wire logic self_test_done,
	input wire logic self_test_pass,
	// output groups, true and complement
	output output_group_t output_group_one,
	output output_group_t output_group_one_n,
	output output_group_t output_group_two,
	output output_group_t output_group_two_n,
	// indicators and interrupt
	output logic self_test_indicator,
	output logic binning_indicator,
	output logic trigger_source_indicator,
	output logic irq
);

	// ==========================================================
	// helpers
	function automatic logic [2:0] bin_factor(input logic [1:0] code);
		case (code)
			BIN_1X: bin_factor = 3'h1;
			BIN_2X: bin_factor = 3'h2;
			default: bin_factor = 3'h4;
		endcase
	endfunction : bin_factor

	function automatic logic [10:0] pre_lines(input logic [1:0] code);
		case (code)
			BIN_1X: pre_lines = PRE_LINES_1X;
			BIN_2X: pre_lines = PRE_LINES_2X;
			default: pre_lines = PRE_LINES_4X;
		endcase
	endfunction : pre_lines

	function automatic logic [10:0] active_lines(input logic [1:0] code);
		case (code)
			BIN_1X: active_lines = ACTIVE_LINES_1X;
			BIN_2X: active_lines = ACTIVE_LINES_1X >> 1;
			default: active_lines = ACTIVE_LINES_1X >> 2;
		endcase
	endfunction : active_lines

	// ==========================================================
	// registers
	logic [5:0] ctrl_q;
	logic [EVT_W-1:0] irq_stat_q;
	logic [EVT_W-1:0] irq_mask_q;
	logic [EVT_W-1:0] evt;
	logic [31:0] rdata_d;
	logic [31:0] status_w;
	logic run;

	assign run = ctrl_q[CTRL_ENABLE_BIT] & init_done;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			ctrl_q <= CTRL_RESET;
		else if (reg_wr && reg_addr == CTRL_ADDR)
			ctrl_q <= reg_wdata[5:0];
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_mask_q <= '0;
		else if (reg_wr && reg_addr == IRQ_MASK_ADDR)
			irq_mask_q <= reg_wdata[EVT_W-1:0];
	end

	// set wins over write-one-to-clear
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_stat_q <= '0;
		else if (reg_wr && reg_addr == IRQ_STAT_ADDR)
			irq_stat_q <= (irq_stat_q & ~reg_wdata[EVT_W-1:0]) | evt;
		else
			irq_stat_q <= irq_stat_q | evt;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_q & irq_mask_q);
	end

	// ==========================================================
	// sensor clock and trigger synchronisers
	logic [2:0] sclk_sync_q;
	logic [2:0] trig_sync_q;
	logic sclk_edge;
	logic trig_rise;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sclk_sync_q <= '0;
			trig_sync_q <= '0;
		end
		else
		begin
			sclk_sync_q <= {sclk_sync_q[1:0], sensor_clk};
			trig_sync_q <= {trig_sync_q[1:0], ext_trigger};
		end
	end

	assign sclk_edge = sclk_sync_q[2] ^ sclk_sync_q[1];
	assign trig_rise = trig_sync_q[1] & ~trig_sync_q[2];

	// ==========================================================
	// pixel clock divider
	logic [1:0] hbin_q;
	logic [1:0] vbin_q;
	logic [2:0] edge_cnt_q;
	logic pclk_q;
	logic pclk_toggle;
	logic tick;

	assign pclk_toggle = sclk_edge && (edge_cnt_q == bin_factor(hbin_q) - 3'h1);
	assign tick = pclk_toggle && !pclk_q;

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			edge_cnt_q <= '0;
			pclk_q <= 1'b0;
		end
		else if (!run)
		begin
			edge_cnt_q <= '0;
			pclk_q <= 1'b0;
		end
		else if (sclk_edge)
		begin
			edge_cnt_q <= pclk_toggle ? 3'h0 : edge_cnt_q + 3'h1;
			pclk_q <= pclk_q ^ pclk_toggle;
		end
	end

	// ==========================================================
	// frame sequencer
	frame_state_t state_q;
	logic [11:0] cnt_q;
	logic [10:0] line_q;
	logic [10:0] lines_total;
	logic [11:0] words_line;
	logic lsync_q;
	logic fsync_q;
	logic trig_pend_q;
	logic start;
	logic line_done;

	assign lines_total = pre_lines(vbin_q) + active_lines(vbin_q);
	assign words_line = WORDS_1X >> ((hbin_q == BIN_1X || hbin_q == BIN_2X) ?
		hbin_q : BIN_4X);
	assign line_done = cnt_q == words_line - 12'h001;
	assign start = (state_q == ST_IDLE) && tick &&
		(ctrl_q[CTRL_EXT_TRIG_BIT] ? trig_pend_q : 1'b1);

	// external trigger held until a frame starts; new trigger wins
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			trig_pend_q <= 1'b0;
		else if (trig_rise && ctrl_q[CTRL_EXT_TRIG_BIT])
			trig_pend_q <= 1'b1;
		else if (start || !run)
			trig_pend_q <= 1'b0;
	end

	// binning taken at frame boundaries only
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hbin_q <= BIN_1X;
			vbin_q <= BIN_1X;
		end
		else if (state_q == ST_IDLE && !pclk_q)
		begin
			hbin_q <= ctrl_q[CTRL_HBIN_LSB +: 2];
			vbin_q <= ctrl_q[CTRL_VBIN_LSB +: 2];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			line_q <= '0;
			lsync_q <= 1'b0;
			fsync_q <= 1'b0;
		end
		else if (!run)
		begin
			state_q <= ST_IDLE;
			cnt_q <= '0;
			line_q <= '0;
			lsync_q <= 1'b0;
			fsync_q <= 1'b0;
		end
		else if (tick)
		begin
			cnt_q <= cnt_q + 12'h001;
			case (state_q)
				ST_IDLE:
					if (start)
					begin
						fsync_q <= 1'b1;
						cnt_q <= '0;
						line_q <= '0;
						state_q <= ST_LEAD;
					end
				ST_LEAD:
					if (cnt_q == FRAME_LEAD - 12'h001)
					begin
						lsync_q <= 1'b1;
						cnt_q <= '0;
						state_q <= ST_LINE;
					end
				ST_LINE:
					if (line_done)
					begin
						lsync_q <= 1'b0;
						cnt_q <= '0;
						line_q <= line_q + 11'h001;
						state_q <= (line_q == lines_total - 11'h001) ?
							ST_TAIL : ST_GAP;
					end
				ST_GAP:
					if (cnt_q == LINE_GAP - 12'h001)
					begin
						lsync_q <= 1'b1;
						cnt_q <= '0;
						state_q <= ST_LINE;
					end
				ST_TAIL:
					if (cnt_q == FRAME_TAIL - 12'h001)
					begin
						fsync_q <= 1'b0;
						cnt_q <= '0;
						state_q <= ST_IDLE;
					end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// events
	always_comb
	begin
		evt = '0;
		evt[EVT_FRAME_START] = start && run;
		evt[EVT_FRAME_END] = run && tick && state_q == ST_TAIL &&
			cnt_q == FRAME_TAIL - 12'h001;
		evt[EVT_TRIG_BUSY] = trig_rise && ctrl_q[CTRL_EXT_TRIG_BIT] &&
			state_q != ST_IDLE;
	end

	// ==========================================================
	// output groups
	logic word_slot;
	output_group_t grp1_d;
	output_group_t grp2_d;

	// a word goes out with each rising pixel clock while a line is open
	assign word_slot = run && tick && (state_q == ST_LINE ||
		(lsync_q == 1'b0 && fsync_q && cnt_q == LINE_GAP - 12'h001 &&
		state_q == ST_GAP) ||
		(state_q == ST_LEAD && cnt_q == FRAME_LEAD - 12'h001)) &&
		!(state_q == ST_LINE && line_done);

	always_comb
	begin
		grp1_d = output_group_one;
		grp2_d = output_group_two;
		grp1_d.pixel_clock_out = pclk_q ^ (run && pclk_toggle);
		grp2_d.pixel_clock_out = pclk_q ^ (run && pclk_toggle);
		if (word_slot)
		begin
			grp1_d.word_first = pixel_in.ch_a;
			grp1_d.word_second = pixel_in.ch_b;
			grp2_d.word_first = pixel_in.ch_c;
			grp2_d.word_second = pixel_in.ch_d;
		end
		else if (tick || !run)
		begin
			grp1_d.word_first = '0;
			grp1_d.word_second = '0;
			grp2_d.word_first = '0;
			grp2_d.word_second = '0;
		end
	end

	// syncs are registered in the same cycle as the sequencer flags, with the clock edge
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			output_group_one <= '0;
			output_group_two <= '0;
			output_group_one_n <= '1;
			output_group_two_n <= '1;
			pixel_take <= 1'b0;
		end
		else
		begin
			output_group_one <= grp1_d;
			output_group_two <= grp2_d;
			output_group_one.line_sync <= lsync_d(1'b0);
			output_group_two.line_sync <= lsync_d(1'b0);
			output_group_one.frame_sync <= fsync_d(1'b0);
			output_group_two.frame_sync <= fsync_d(1'b0);
			output_group_one_n <= ~grp1_d;
			output_group_two_n <= ~grp2_d;
			output_group_one_n.line_sync <= ~lsync_d(1'b0);
			output_group_two_n.line_sync <= ~lsync_d(1'b0);
			output_group_one_n.frame_sync <= ~fsync_d(1'b0);
			output_group_two_n.frame_sync <= ~fsync_d(1'b0);
			pixel_take <= word_slot;
		end
	end

	function automatic logic lsync_d(input logic dummy);
		lsync_d = dummy | (run & lsync_q_next());
	endfunction : lsync_d

	function automatic logic fsync_d(input logic dummy);
		fsync_d = dummy | (run & fsync_q_next());
	endfunction : fsync_d

	function automatic logic lsync_q_next();
		if (!tick)
			lsync_q_next = lsync_q;
		else if (state_q == ST_LINE)
			lsync_q_next = !line_done;
		else if (state_q == ST_GAP)
			lsync_q_next = cnt_q == LINE_GAP - 12'h001;
		else if (state_q == ST_LEAD)
			lsync_q_next = cnt_q == FRAME_LEAD - 12'h001;
		else
			lsync_q_next = 1'b0;
	endfunction : lsync_q_next

	function automatic logic fsync_q_next();
		if (!tick)
			fsync_q_next = fsync_q;
		else if (state_q == ST_IDLE)
			fsync_q_next = start;
		else if (state_q == ST_TAIL)
			fsync_q_next = cnt_q != FRAME_TAIL - 12'h001;
		else
			fsync_q_next = 1'b1;
	endfunction : fsync_q_next

	// ==========================================================
	// indicators
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			self_test_indicator <= 1'b0;
			binning_indicator <= 1'b0;
			trigger_source_indicator <= 1'b0;
		end
		else
		begin
			self_test_indicator <= self_test_done & self_test_pass;
			binning_indicator <= (ctrl_q[CTRL_HBIN_LSB +: 2] != BIN_1X) ||
				(ctrl_q[CTRL_VBIN_LSB +: 2] != BIN_1X);
			trigger_source_indicator <= ctrl_q[CTRL_EXT_TRIG_BIT];
		end
	end

	// ==========================================================
	// read port
	always_comb
	begin
		status_w = '0;
		status_w[STAT_SELF_TEST_BIT] = self_test_indicator;
		status_w[STAT_FRAME_BIT] = fsync_q;
		status_w[STAT_LINE_BIT] = lsync_q;
		status_w[STAT_INIT_BIT] = init_done;
		rdata_d = '0;
		if (reg_rd)
			case (reg_addr)
				CTRL_ADDR: rdata_d = {26'h0000000, ctrl_q};
				STATUS_ADDR: rdata_d = status_w;
				IRQ_STAT_ADDR: rdata_d = {29'h00000000, irq_stat_q};
				IRQ_MASK_ADDR: rdata_d = {29'h00000000, irq_mask_q};
				default: rdata_d = '0;
			endcase
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= rdata_d;
	end

endmodule : camera_video_output_port

// *** video_out_pkg.sv ***
package video_out_pkg;

	// ==========================================================
	// register map
	localparam logic [3:0] CTRL_ADDR = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;
	localparam logic [3:0] IRQ_STAT_ADDR = 4'h8;
	localparam logic [3:0] IRQ_MASK_ADDR = 4'hc;

	// ==========================================================
	// control fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_HBIN_LSB = 1;
	localparam int CTRL_VBIN_LSB = 3;
	localparam int CTRL_EXT_TRIG_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	// ==========================================================
	// status and event fields
	localparam int STAT_SELF_TEST_BIT = 0;
	localparam int STAT_FRAME_BIT = 1;
	localparam int STAT_LINE_BIT = 2;
	localparam int STAT_INIT_BIT = 3;
	localparam int EVT_FRAME_START = 0;
	localparam int EVT_FRAME_END = 1;
	localparam int EVT_TRIG_BUSY = 2;
	localparam int EVT_W = 3;

	// ==========================================================
	// binning codes
	localparam logic [1:0] BIN_1X = 2'h0;
	localparam logic [1:0] BIN_2X = 2'h1;
	localparam logic [1:0] BIN_4X = 2'h2;

	// ==========================================================
	// frame geometry
	localparam int PIX_W = 12;
	localparam int NOMINAL_PIXEL_CLOCK_OUT_MHZ = 40;
	localparam logic [10:0] ACTIVE_LINES_1X = 11'h400;
	localparam logic [10:0] PRE_LINES_1X = 11'h006;
	localparam logic [10:0] PRE_LINES_2X = 11'h003;
	localparam logic [10:0] PRE_LINES_4X = 11'h002;
	localparam logic [11:0] WORDS_1X = 12'h300;
	localparam logic [11:0] LINE_GAP = 12'h010;
	localparam logic [11:0] FRAME_LEAD = 12'h004;
	localparam logic [11:0] FRAME_TAIL = 12'h004;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [PIX_W-1:0] ch_a;
		logic [PIX_W-1:0] ch_b;
		logic [PIX_W-1:0] ch_c;
		logic [PIX_W-1:0] ch_d;
	} pixel_quad_t;

	typedef struct packed {
		logic [PIX_W-1:0] word_first;
		logic [PIX_W-1:0] word_second;
		logic pixel_clock_out;
		logic line_sync;
		logic frame_sync;
	} output_group_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LEAD,
		ST_LINE,
		ST_GAP,
		ST_TAIL
	} frame_state_t;

endpackage : video_out_pkg

// *** video_port_props.sv ***
`timescale 1ns/10ps
module video_port_props
	import video_out_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic arst_n,
	// register and sensor side
	input wire logic reg_wr,
	input wire logic init_done,
	// video groups and indicators
	input wire output_group_t output_group_one,
	input wire output_group_t output_group_one_n,
	input wire output_group_t output_group_two,
	input wire output_group_t output_group_two_n,
	input wire logic binning_indicator,
	input wire logic trigger_source_indicator
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// ==========
	// sequences
	sequence s_frame_open;
		$rose(output_group_one.frame_sync);
	endsequence
	sequence s_sync_rise;
		$rose(output_group_one.frame_sync) || $rose(output_group_one.line_sync);
	endsequence
	sequence s_recent_write;
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
	endsequence

	// ==========
	// wire checks
	a_true_compl: assert property (output_group_one_n == ~output_group_one && output_group_two_n == ~output_group_two)
		else $error("complement group mismatch");
	a_group_align: assert property (output_group_two.pixel_clock_out == output_group_one.pixel_clock_out && output_group_two.line_sync == output_group_one.line_sync && output_group_two.frame_sync == output_group_one.frame_sync)
		else $error("groups not aligned");
	a_rise_on_clock: assert property (s_sync_rise |-> $rose(output_group_one.pixel_clock_out))
		else $error("sync rose off the pixel clock");
	a_word_on_clock: assert property ($changed(output_group_one.word_first) && output_group_one.line_sync |-> $rose(output_group_one.pixel_clock_out))
		else $error("word changed off the pixel clock");
	a_line_in_frame: assert property (output_group_one.line_sync |-> output_group_one.frame_sync)
		else $error("line outside frame");
	a_frame_lead: assert property (s_frame_open |-> !output_group_one.line_sync [*8])
		else $error("line too soon after frame start");
	a_init_idle: assert property (!init_done [*3] |-> !output_group_one.frame_sync && !output_group_one.line_sync)
		else $error("sync high before init");
	a_bin_steady: assert property ($changed(binning_indicator) |-> s_recent_write)
		else $error("binning indicator moved alone");
	a_trig_steady: assert property ($changed(trigger_source_indicator) |-> s_recent_write)
		else $error("trigger indicator moved alone");
endmodule : video_port_props

bind camera_video_output_port video_port_props video_port_props_inst (
	.core_clk(core_clk),
	.arst_n(arst_n),
	.reg_wr(reg_wr),
	.init_done(init_done),
	.output_group_one(output_group_one),
	.output_group_one_n(output_group_one_n),
	.output_group_two(output_group_two),
	.output_group_two_n(output_group_two_n),
	.binning_indicator(binning_indicator),
	.trigger_source_indicator(trigger_source_indicator)
);

// *** frame_grabber_model.sv ***
`timescale 1ns/10ps
module frame_grabber_model
	import video_out_pkg::*;
(
	// clock and link
	input wire logic core_clk,
	input wire output_group_t link,
	// capture results
	output logic [15:0] words_q,
	output logic [15:0] lines_q,
	output logic [31:0] period_q,
	output logic [23:0] last_q
);
	logic [31:0] cyc = 32'h0;
	logic [31:0] mark = 32'h0;
	logic in_line = 1'b0;
	initial
	begin
		words_q = 16'h0;
		lines_q = 16'h0;
		period_q = 32'h0;
		last_q = 24'h0;
	end
	always @(posedge core_clk)
		cyc <= cyc + 32'h1;
	// ==========
	// capture on the falling pixel clock
	always @(negedge link.pixel_clock_out)
	begin
		period_q <= cyc - mark;
		mark <= cyc;
		in_line <= link.line_sync;
		if (link.line_sync)
		begin
			words_q <= in_line ? words_q + 16'h1 : 16'h1;
			last_q <= {link.word_first, link.word_second};
		end
		if (!link.frame_sync)
			lines_q <= 16'h0;
		else if (in_line && !link.line_sync)
			lines_q <= lines_q + 16'h1;
	end
endmodule : frame_grabber_model

// *** camera_video_output_port_test.sv ***
`timescale 1ns/10ps
module camera_video_output_port_test;
	import video_out_pkg::*;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic sensor_clk = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic ext_trigger = 1'b0;
	pixel_quad_t pixel_in = '0;
	logic init_done = 1'b0;
	logic st_done = 1'b0;
	logic st_pass = 1'b0;
	output_group_t g1, g1_n, g2, g2_n;
	logic st_ind, bin_ind, trig_ind, irq;
	logic [15:0] words_one, words_two, lines_one, lines_two;
	logic [31:0] period_one, period_two, d;
	logic [23:0] last_one, last_two;
	int fail_count = 0;
	int checks_done = 0;
	int h;
	int v;
	int n;
	logic take;
	int takes = 0;

	always #25 core_clk = ~core_clk;
	initial #13 forever #200 sensor_clk = ~sensor_clk;
	always @(posedge core_clk)
		if (take === 1'b1)
			takes <= takes + 1;

	camera_video_output_port camera_video_output_port_inst (.core_clk(core_clk),
		.arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sensor_clk(sensor_clk), .ext_trigger(ext_trigger),
		.pixel_in(pixel_in), .pixel_take(take), .init_done(init_done),
		.self_test_done(st_done), .self_test_pass(st_pass),
		.output_group_one(g1), .output_group_one_n(g1_n),
		.output_group_two(g2), .output_group_two_n(g2_n),
		.self_test_indicator(st_ind), .binning_indicator(bin_ind),
		.trigger_source_indicator(trig_ind), .irq(irq));
	frame_grabber_model frame_grabber_model_inst (.core_clk(core_clk),
		.link(g1), .words_q(words_one), .lines_q(lines_one),
		.period_q(period_one), .last_q(last_one));
	frame_grabber_model frame_grabber_model_inst_two (.core_clk(core_clk),
		.link(g2), .words_q(words_two), .lines_q(lines_two),
		.period_q(period_two), .last_q(last_two));

	// ==========
	// helpers
	function automatic int bin_shift(input int hb);
		return hb > 1 ? 2 : hb;
	endfunction : bin_shift
	function automatic logic [31:0] line_words(input int hb);
		return 32'(WORDS_1X) >> bin_shift(hb);
	endfunction : line_words
	function automatic logic bin_on(input int hb, input int vb);
		return hb != 0 || vb != 0;
	endfunction : bin_on
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] wd);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task automatic wait_lines(input int k);
		n = 0;
		while (lines_one < k && n < 20000)
		begin
			@(posedge core_clk);
			n++;
		end
		check(n < 20000, 1);
	endtask : wait_lines
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// ==========
	// watchdog
	initial
	begin
		#(60000 * 50);
		fail_count++;
		test_done();
	end

	// ==========
	// tests
	initial
	begin
		void'($urandom(32'ha8e4706a));
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(CTRL_ADDR);
		check(d, 32'h0);
		rd(4'h2);
		check(d, 32'h0);
		check({st_ind, bin_ind, trig_ind, irq}, 32'h0);
		for (int p = 0; p < 2; p++)
		begin
			st_done <= 1'b1;
			st_pass <= p[0];
			repeat (4) @(posedge core_clk);
			check(st_ind, p);
		end
		for (int i = 0; i < 18; i++)
		begin
			h = i % 3;
			v = (i / 3) % 3;
			wr(CTRL_ADDR, 32'((i / 9) << 5 | v << 3 | h << 1));
			repeat (3) @(posedge core_clk);
			check(bin_ind, bin_on(h, v));
			check(trig_ind, i / 9);
		end
		wr(CTRL_ADDR, 32'h1);
		repeat (200) @(posedge core_clk);
		check(g1.frame_sync, 0);
		h = $urandom_range(3);
		v = $urandom_range(3);
		pixel_in <= pixel_quad_t'(48'({$urandom, $urandom}));
		wr(IRQ_MASK_ADDR, 32'h7);
		wr(CTRL_ADDR, 32'(v << 3 | h << 1 | 1));
		init_done <= 1'b1;
		wait_lines(1);
		check(words_one, line_words(h));
		check(words_two, line_words(h));
		check(last_one, {pixel_in.ch_a, pixel_in.ch_b});
		check(last_two, {pixel_in.ch_c, pixel_in.ch_d});
		check(g1.frame_sync, 1);
		check(takes, line_words(h));
		n = 8 << bin_shift(h);
		check(period_one >= n - 1 && period_one <= n + 1, 1);
		check(irq, 1);
		rd(IRQ_STAT_ADDR);
		check(d & 32'h1, 32'h1);
		wr(IRQ_STAT_ADDR, 32'h1);
		repeat (3) @(posedge core_clk);
		check(irq, 0);
		wait_lines(2);
		check(lines_two, 2);
		wr(CTRL_ADDR, 32'h0);
		repeat (3) @(posedge core_clk);
		check(g1.frame_sync, 0);
		wr(CTRL_ADDR, 32'h21);
		repeat (100) @(posedge core_clk);
		check(g1.frame_sync, 0);
		ext_trigger <= 1'b1;
		repeat (4) @(posedge core_clk);
		ext_trigger <= 1'b0;
		n = 0;
		while (!g1.frame_sync && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
		check(g1.frame_sync, 1);
		ext_trigger <= 1'b1;
		repeat (4) @(posedge core_clk);
		ext_trigger <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(IRQ_STAT_ADDR);
		check(d & 32'h4, 32'h4);
		wr(CTRL_ADDR, 32'h0);
		repeat (3) @(posedge core_clk);
		test_done();
	end
endmodule : camera_video_output_port_test
